/* rtl/lin_mode_ctrl.sv */
// mode control and data path of a single-wire link transceiver
// assumes the bus comparator and the transmit pin arrive asynchronously
// What this block does
// - after power-up the transceiver is off with no transmit or receive activity.
// - off mode can be selected in every global chip mode.
// - in off mode bus wake activity is ignored; a latched wake stays on wakeSeen one cycle into off if off is set in chip sleep with the bus dominant.
// - the transceiver mode follows the mode bits where the chip mode allows; normal and receive-only fall back to wake-capable outside chip normal or stop.
// - normal mode is entered by a mode write while the chip is in its normal mode.
// - normal mode is allowed only while the chip mode is normal or stop.
// - in normal mode a low transmit input drives dominant and a high one releases the bus.
// - a dominant level held over the enabling period is not sent; only one starting after recessive is.
// - in normal mode the receive output shows the bus, low dominant and high recessive.
// - in receive-only mode the driver is off and the receive output still follows the bus.
// - receive-only mode is entered by command and allowed only in chip normal or stop mode.
// - wake-capable mode is code 01 and still reads 01 after a bus wake.
// - after a bus wake in wake-capable mode the receive output is low until the mode changes.
module lin_mode_ctrl #(
   parameter int ENABLE_CYC = lin_mode_pkg::ENABLE_CYCLES,
   parameter int WAKE_CYC = lin_mode_pkg::WAKE_CYCLES
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   // serial-port mode write and chip mode
   input wire logic modeWrite,
   input wire logic [1:0] busTransceiverModeBits,
   input wire logic [2:0] systemChipMode,
   // controller side pins
   input wire logic linTransmitInput,
   output logic linReceiveOutput,
   // bus side
   input wire logic busLevelIn,
   output logic busDriveDominant,
   // status
   output logic [1:0] activeMode,
   output logic wakeSeen
);
   initial begin
      if (ENABLE_CYC < 1 || WAKE_CYC < 1) $error("cycle counts must be positive");
   end

   typedef enum logic [3:0] {
      ST_OFF = 4'h1,
      ST_WAKE = 4'h2,
      ST_RXONLY = 4'h4,
      ST_NORMAL = 4'h8
   } mode_e;

   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   logic [1:0] rstSync_r;
   logic rstN;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync_r <= 2'h0;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstN = rstSync_r[1];

   // three stages; a change counts when stages two and three agree
   logic [2:0] txSync_r, busSync_r;
   logic txIn_r, busIn_r;
   logic txIn_nxt, busIn_nxt;
   always_comb begin
      txIn_nxt = (txSync_r[1] == txSync_r[2]) ? txSync_r[2] : txIn_r;
      busIn_nxt = (busSync_r[1] == busSync_r[2]) ? busSync_r[2] : busIn_r;
   end
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         txSync_r <= 3'h7;
         busSync_r <= 3'h7;
         txIn_r <= 1'b1;
         busIn_r <= 1'b1;
      end else if (clkEn) begin
         txSync_r <= {txSync_r[1:0], linTransmitInput};
         busSync_r <= {busSync_r[1:0], busLevelIn};
         txIn_r <= txIn_nxt;
         busIn_r <= busIn_nxt;
      end
   end

   // ----------------------------------------
   // mode state machine
   // ----------------------------------------
   mode_e state_r, state_nxt;
   logic wake_r, wake_nxt;
   logic [15:0] enCnt_r, enCnt_nxt;
   logic [15:0] wkCnt_r, wkCnt_nxt;
   logic armed_r, armed_nxt;
   logic chipActive;
   logic enDone;

   always_comb begin
      chipActive = (systemChipMode == lin_mode_pkg::CHIP_NORMAL) ||
                   (systemChipMode == lin_mode_pkg::CHIP_STOP);
      state_nxt = state_r;
      if (modeWrite) begin
         case (busTransceiverModeBits)
            lin_mode_pkg::MODE_OFF: state_nxt = ST_OFF;
            lin_mode_pkg::MODE_WAKE: state_nxt = ST_WAKE;
            lin_mode_pkg::MODE_RXONLY: state_nxt = chipActive ? ST_RXONLY : state_r;
            lin_mode_pkg::MODE_NORMAL:
               state_nxt = (systemChipMode == lin_mode_pkg::CHIP_NORMAL) ? ST_NORMAL : state_r;
            default: state_nxt = state_r;
         endcase
      end
      // leaving allowed chip modes drops active modes back to wake monitoring
      if (!modeWrite && !chipActive && (state_r == ST_NORMAL || state_r == ST_RXONLY)) begin
         state_nxt = ST_WAKE;
      end
   end

   always_comb begin
      enDone = (enCnt_r >= 16'(ENABLE_CYC));
      enCnt_nxt = enCnt_r;
      armed_nxt = armed_r;
      if (state_nxt != ST_NORMAL || state_r != ST_NORMAL) begin
         enCnt_nxt = 16'h0;
         armed_nxt = 1'b0;
      end else begin
         if (!enDone) begin
            enCnt_nxt = enCnt_r + 16'h1;
         end
         if (enDone && txIn_r) begin
            armed_nxt = 1'b1;
         end
      end
   end

   always_comb begin
      wkCnt_nxt = 16'h0;
      wake_nxt = wake_r;
      if (state_nxt != state_r || state_r != ST_WAKE) begin
         wake_nxt = 1'b0;
      end else if (!busIn_r) begin
         wkCnt_nxt = (wkCnt_r >= 16'(WAKE_CYC)) ? wkCnt_r : wkCnt_r + 16'h1;
         if (wkCnt_r >= 16'(WAKE_CYC)) begin
            wake_nxt = 1'b1;
         end
      end
      if (systemChipMode == lin_mode_pkg::CHIP_SLEEP && state_r == ST_WAKE && wake_r && !busIn_r) begin
         wake_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_r <= ST_OFF;
         enCnt_r <= 16'h0;
         armed_r <= 1'b0;
         wkCnt_r <= 16'h0;
         wake_r <= 1'b0;
      end else if (clkEn) begin
         state_r <= state_nxt;
         enCnt_r <= enCnt_nxt;
         armed_r <= armed_nxt;
         wkCnt_r <= wkCnt_nxt;
         wake_r <= wake_nxt;
      end
   end

   // ----------------------------------------
   // data path and outputs
   // ----------------------------------------
   logic rxLevel, bufValid, bufReady, rxWord;
   logic drive_r, drive_nxt;
   logic [1:0] modeOut_r, modeOut_nxt;

   always_comb begin
      drive_nxt = 1'b0;
      rxLevel = 1'b1;
      modeOut_nxt = lin_mode_pkg::MODE_OFF;
      case (state_r)
         ST_OFF: rxLevel = 1'b1;
         ST_WAKE: begin
            modeOut_nxt = lin_mode_pkg::MODE_WAKE;
            rxLevel = !wake_r;
         end
         ST_RXONLY: begin
            modeOut_nxt = lin_mode_pkg::MODE_RXONLY;
            rxLevel = busIn_r;
         end
         ST_NORMAL: begin
            modeOut_nxt = lin_mode_pkg::MODE_NORMAL;
            drive_nxt = armed_r && !txIn_r;
            rxLevel = busIn_r;
         end
         default: rxLevel = 1'b1;
      endcase
   end

   // receive levels through the two-entry buffer; drain always ready
   rx_skid_buffer #(.WIDTH(1)) rxBuf (
      .clk(clk),
      .rstN(rstN),
      .clkEn(clkEn),
      .inValid(1'b1),
      .inReady(bufReady),
      .inData(rxLevel),
      .outValid(bufValid),
      .outReady(1'b1),
      .outData(rxWord)
   );

   logic rxOut_r, rxOut_nxt;
   always_comb begin
      rxOut_nxt = (bufValid && bufReady) ? rxWord : rxOut_r;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         drive_r <= 1'b0;
         modeOut_r <= lin_mode_pkg::MODE_OFF;
         rxOut_r <= 1'b1;
      end else if (clkEn) begin
         drive_r <= drive_nxt;
         modeOut_r <= modeOut_nxt;
         rxOut_r <= rxOut_nxt;
      end
   end

   assign busDriveDominant = drive_r;
   assign linReceiveOutput = rxOut_r;
   assign activeMode = modeOut_r;
   assign wakeSeen = wake_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   off_no_drive_a: assert property (@(posedge clk) disable iff (!rstN)
      (clkEn && state_r == ST_OFF) |=> !busDriveDominant) else $error("driver active in off mode");
   rxonly_no_drive_a: assert property (@(posedge clk) disable iff (!rstN)
      (clkEn && state_r == ST_RXONLY) |=> !busDriveDominant) else $error("driver active in receive-only");
   off_no_wake_a: assert property (@(posedge clk) disable iff (!rstN)
      (state_r == ST_OFF) |-> !wake_r) else $error("wake latched in off mode");
   normal_gate_a: assert property (@(posedge clk) disable iff (!rstN)
      (clkEn && $changed(state_r) && state_r == ST_NORMAL) |-> $past(systemChipMode) == lin_mode_pkg::CHIP_NORMAL)
      else $error("normal entered outside chip normal");
   rxonly_gate_a: assert property (@(posedge clk) disable iff (!rstN)
      ($changed(state_r) && state_r == ST_RXONLY) |-> $past(chipActive)) else $error("receive-only not allowed");
   early_dominant_a: assert property (@(posedge clk) disable iff (!rstN)
      (clkEn && state_r == ST_NORMAL && !armed_r) |=> !busDriveDominant) else $error("dominant before arming");
   wake_code_a: assert property (@(posedge clk) disable iff (!rstN)
      (state_r == ST_WAKE && wake_r) |=> activeMode == lin_mode_pkg::MODE_WAKE) else $error("wake code lost");
   mode_write_a: assert property (@(posedge clk) disable iff (!rstN)
      (clkEn && !modeWrite && chipActive) |=> $stable(state_r)) else $error("mode moved without write");
   off_select_a: assert property (@(posedge clk) disable iff (!rstN)
      (clkEn && modeWrite && busTransceiverModeBits == lin_mode_pkg::MODE_OFF) |=> state_r == ST_OFF)
      else $error("off not taken");
endmodule : lin_mode_ctrl

/* rtl/lin_mode_pkg.sv */
// constants for the single-wire link transceiver mode control
// assumes a 200 MHz core clock
package lin_mode_pkg;
   // transceiver mode field encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_WAKE = 2'h1;
   localparam logic [1:0] MODE_RXONLY = 2'h2;
   localparam logic [1:0] MODE_NORMAL = 2'h3;
   // global chip mode encodings
   localparam logic [2:0] CHIP_NORMAL = 3'h0;
   localparam logic [2:0] CHIP_STOP = 3'h1;
   localparam logic [2:0] CHIP_SLEEP = 3'h2;
   localparam logic [2:0] CHIP_RESTART = 3'h3;
   localparam logic [2:0] CHIP_FAILSAFE = 3'h4;
   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int ENABLE_TIME_NS = 10000;
   localparam int ENABLE_CYCLES = (ENABLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_FILTER_NS = 30000;
   localparam int WAKE_CYCLES = (WAKE_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : lin_mode_pkg

/* rtl/rx_skid_buffer.sv */
// two-entry buffer with valid/ready on both sides
// assumes producer and consumer on the same clock
module rx_skid_buffer #(
   parameter int WIDTH = 1
) (
   // clock and control
   input wire logic clk,
   input wire logic rstN,
   input wire logic clkEn,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   initial begin
      if (WIDTH < 1) $error("width must be at least one");
   end

   logic [WIDTH-1:0] mem_r [2];
   logic [WIDTH-1:0] mem_nxt [2];
   logic wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
   logic [1:0] count_r, count_nxt;
   logic [WIDTH-1:0] outData_r, outData_nxt;
   logic outValid_r, outValid_nxt;
   logic push, pop;

   // next state of storage and pointers
   always_comb begin
      push = inValid && (count_r != 2'h2);
      pop = (count_r != 2'h0) && (!outValid_r || outReady);
      mem_nxt = mem_r;
      wrPtr_nxt = wrPtr_r;
      rdPtr_nxt = rdPtr_r;
      count_nxt = count_r;
      outData_nxt = outData_r;
      outValid_nxt = outValid_r;
      if (outValid_r && outReady) begin
         outValid_nxt = 1'b0;
      end
      if (push) begin
         mem_nxt[wrPtr_r] = inData;
         wrPtr_nxt = ~wrPtr_r;
      end
      if (pop) begin
         outData_nxt = mem_r[rdPtr_r];
         outValid_nxt = 1'b1;
         rdPtr_nxt = ~rdPtr_r;
      end
      count_nxt = count_r + {1'b0, push} - {1'b0, pop};
   end

   // register stage
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wrPtr_r <= 1'b0;
         rdPtr_r <= 1'b0;
         count_r <= 2'h0;
         outData_r <= '1;
         outValid_r <= 1'b0;
      end else if (clkEn) begin
         mem_r <= mem_nxt;
         wrPtr_r <= wrPtr_nxt;
         rdPtr_r <= rdPtr_nxt;
         count_r <= count_nxt;
         outData_r <= outData_nxt;
         outValid_r <= outValid_nxt;
      end
   end

   assign inReady = (count_r != 2'h2);
   assign outValid = outValid_r;
   assign outData = outData_r;
endmodule : rx_skid_buffer

/* bench/lin_bus_partner.sv */
// far side of the transceiver: the single-wire bus and the other nodes on it
// assumes the design pulls the bus dominant while busDriveDominant is high
module lin_bus_partner (
   // drivers of the wire
   input wire logic dutDominant,
   input wire logic nodeDominant,
   // wire level, low for dominant
   output logic busLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   // open-drain wire with pull-up: any driver pulls it low
   assign busLevel = !(dutDominant || nodeDominant);
endmodule : lin_bus_partner

/* bench/tb.sv */
// self-checking bench of the transceiver mode control
// assumes the bus partner model and short enable and wake counts
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EN_CYC = 8;
   localparam int WK_CYC = 8;
   logic clk, rst_n, clkEn, modeWrite, linTransmitInput, nodeDominant;
   logic [1:0] modeBits, activeMode;
   logic [2:0] chipMode;
   logic rxOut, drive, busLevel, wakeSeen;
   int errors, check_count, expMode, req;

   lin_mode_ctrl #(.ENABLE_CYC(EN_CYC), .WAKE_CYC(WK_CYC)) dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
      .modeWrite(modeWrite), .busTransceiverModeBits(modeBits), .systemChipMode(chipMode),
      .linTransmitInput(linTransmitInput), .linReceiveOutput(rxOut), .busLevelIn(busLevel),
      .busDriveDominant(drive), .activeMode(activeMode), .wakeSeen(wakeSeen));
   lin_bus_partner bus (.dutDominant(drive), .nodeDominant(nodeDominant), .busLevel(busLevel));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chkBit(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : chkBit
   task automatic chkMode(input string what, input logic [1:0] exp, input logic [1:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : chkMode
   task automatic writeMode(input logic [1:0] m);
      @(posedge clk);
      modeWrite <= 1'b1;
      modeBits <= m;
      @(posedge clk);
      modeWrite <= 1'b0;
      cyc(4);
   endtask : writeMode
   // reference: which mode a request leaves active
   function automatic int predict(input int cur, input int r, input int chip);
      if (r == 3) return (chip == 0) ? 3 : cur;
      if (r == 2) return (chip <= 1) ? 2 : cur;
      return r;
   endfunction : predict
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // clock of 5 ns
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // watchdog, far beyond the expected run
   initial begin
      #100000;
      errors++;
      tally_and_finish();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      modeWrite = 1'b0;
      modeBits = 2'h0;
      chipMode = 3'h0;
      linTransmitInput = 1'b1;
      nodeDominant = 1'b0;
      errors = 0;
      check_count = 0;
      expMode = 0;
      void'($urandom(51));
      cyc(4);
      chkMode("activeMode", 2'h0, activeMode);
      @(posedge clk);
      rst_n <= 1'b1;
      cyc(3);
      chkBit("busDriveDominant", 1'b0, drive);
      chkBit("linReceiveOutput", 1'b1, rxOut);
      // off mode ignores a long dominant bus
      @(posedge clk);
      nodeDominant <= 1'b1;
      cyc(WK_CYC + 20);
      chkBit("wakeSeen", 1'b0, wakeSeen);
      chkBit("linReceiveOutput", 1'b1, rxOut);
      @(posedge clk);
      nodeDominant <= 1'b0;
      // off selectable in every chip mode
      for (int c = 0; c <= 4; c++) begin
         @(posedge clk);
         chipMode <= 3'(c);
         writeMode(lin_mode_pkg::MODE_WAKE);
         writeMode(lin_mode_pkg::MODE_OFF);
         chkMode("activeMode", lin_mode_pkg::MODE_OFF, activeMode);
      end
      // random chip modes and requests against the reference
      repeat (40) begin
         @(posedge clk);
         chipMode <= 3'($urandom_range(4));
         cyc(4);
         if (chipMode > 3'h1 && expMode >= 2) expMode = 1;
         req = $urandom_range(3);
         writeMode(2'(req));
         expMode = predict(expMode, req, int'(chipMode));
         chkMode("activeMode", 2'(expMode), activeMode);
      end
      // dominant held over the enable period is not sent
      @(posedge clk);
      chipMode <= lin_mode_pkg::CHIP_NORMAL;
      linTransmitInput <= 1'b0;
      writeMode(lin_mode_pkg::MODE_NORMAL);
      cyc(EN_CYC + 15);
      chkBit("busDriveDominant", 1'b0, drive);
      @(posedge clk);
      linTransmitInput <= 1'b1;
      cyc(10);
      @(posedge clk);
      linTransmitInput <= 1'b0;
      cyc(12);
      chkBit("busDriveDominant", 1'b1, drive);
      chkBit("linReceiveOutput", 1'b0, rxOut);
      @(posedge clk);
      linTransmitInput <= 1'b1;
      cyc(12);
      chkBit("busDriveDominant", 1'b0, drive);
      chkBit("linReceiveOutput", 1'b1, rxOut);
      // receive-only: driver off, receiver follows other nodes
      writeMode(lin_mode_pkg::MODE_RXONLY);
      @(posedge clk);
      linTransmitInput <= 1'b0;
      nodeDominant <= 1'b1;
      cyc(12);
      chkBit("busDriveDominant", 1'b0, drive);
      chkBit("linReceiveOutput", 1'b0, rxOut);
      @(posedge clk);
      linTransmitInput <= 1'b1;
      nodeDominant <= 1'b0;
      cyc(12);
      chkBit("linReceiveOutput", 1'b1, rxOut);
      // wake-capable: bus wake latches a low receive output
      writeMode(lin_mode_pkg::MODE_WAKE);
      @(posedge clk);
      nodeDominant <= 1'b1;
      cyc(WK_CYC + 20);
      @(posedge clk);
      nodeDominant <= 1'b0;
      cyc(20);
      chkBit("wakeSeen", 1'b1, wakeSeen);
      chkBit("linReceiveOutput", 1'b0, rxOut);
      chkMode("activeMode", lin_mode_pkg::MODE_WAKE, activeMode);
      writeMode(lin_mode_pkg::MODE_OFF);
      cyc(4);
      chkBit("linReceiveOutput", 1'b1, rxOut);
      chkBit("wakeSeen", 1'b0, wakeSeen);
      // frozen clock enable: a mode write is not taken
      @(posedge clk);
      clkEn <= 1'b0;
      writeMode(lin_mode_pkg::MODE_NORMAL);
      chkMode("activeMode", lin_mode_pkg::MODE_OFF, activeMode);
      @(posedge clk);
      clkEn <= 1'b1;
      cyc(4);
      chkMode("activeMode", lin_mode_pkg::MODE_OFF, activeMode);
      tally_and_finish();
   end
endmodule : tb
